// ==== hdl/bsm_multiplier.sv ====
// Sequential signed 16x16 Booth multiplier of the extended math unit
`timescale 1ns/1ps
module bsm_multiplier
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Command from the signed_multiply_op decode
   input wire logic start,
   input wire bsm_pkg::bsm_operand_type operand,
   // Result
   output bsm_pkg::bsm_result_type result
);
   bsm_pkg::bsm_state_type state;
   bsm_pkg::bsm_state_type next_state;
   logic [15:0] mcand;
   logic [15:0] next_mcand;
   logic [15:0] mplier;
   logic [15:0] next_mplier;
   logic prev_bit;
   logic next_prev_bit;
   logic [31:0] partial;
   logic [31:0] next_partial;
   logic [4:0] bit_cnt;
   logic [4:0] next_bit_cnt;
   logic [6:0] cyc_cnt;
   logic [6:0] next_cyc_cnt;
   logic [6:0] limit;
   logic [6:0] next_limit;
   bsm_pkg::bsm_result_type next_result;
   logic [31:0] summed;
   bsm_pkg::bsm_op_type op;

   // Arithmetic right shift, sign replicated
   function automatic logic [31:0] asr(input logic [31:0] value);
      asr = {value[31], value[31:1]};
   endfunction

   // Transitions counted from an imaginary zero below the LSB
   function automatic logic [6:0] transitions(input logic [15:0] word);
      logic [6:0] count;
      logic last;
      count = 7'h00;
      last = 1'b0;
      for (int i = 0; i < bsm_pkg::WORD_W; i++)
      begin
         if (word[i] != last)
         begin
            count = 7'(count + 7'h01);
         end
         last = word[i];
      end
      transitions = count;
   endfunction

   bsm_booth_step u_step
   (
      .pair({mplier[0], prev_bit}),
      .partial(partial),
      .mcand(mcand),
      .summed(summed),
      .op(op)
   );

   always_comb
   begin
      next_state = state;
      next_mcand = mcand;
      next_mplier = mplier;
      next_prev_bit = prev_bit;
      next_partial = partial;
      next_bit_cnt = bit_cnt;
      next_cyc_cnt = cyc_cnt;
      next_limit = limit;
      case (state)
         bsm_pkg::ST_IDLE:
         begin
            // Requests while busy are ignored
            if (start)
            begin
               next_mcand = operand.b_reg;
               next_mplier = operand.a_reg;
               next_prev_bit = 1'b0;
               next_partial = bsm_pkg::ZERO_PROD;
               next_bit_cnt = 5'h00;
               next_cyc_cnt = 7'h01;
               next_limit = 7'(bsm_pkg::OVERHEAD_CYC
                  + 7'(bsm_pkg::TRANS_CYC * transitions(operand.a_reg)));
               next_state = bsm_pkg::ST_ADD;
            end
         end
         bsm_pkg::ST_ADD:
         begin
            next_cyc_cnt = 7'(cyc_cnt + 7'h01);
            if (op == bsm_pkg::OP_NONE)
            begin
               next_partial = asr(partial);
               next_prev_bit = mplier[0];
               next_mplier = {1'b0, mplier[15:1]};
               next_bit_cnt = 5'(bit_cnt + 5'h01);
               if (bit_cnt == bsm_pkg::LAST_BIT)
               begin
                  next_state = bsm_pkg::ST_WAIT;
               end
            end
            else
            begin
               next_partial = summed;
               next_state = bsm_pkg::ST_SHIFT;
            end
         end
         bsm_pkg::ST_SHIFT:
         begin
            next_cyc_cnt = 7'(cyc_cnt + 7'h01);
            next_partial = asr(partial);
            next_prev_bit = mplier[0];
            next_mplier = {1'b0, mplier[15:1]};
            next_bit_cnt = 5'(bit_cnt + 5'h01);
            if (bit_cnt == bsm_pkg::LAST_BIT)
            begin
               next_state = bsm_pkg::ST_WAIT;
            end
            else
            begin
               next_state = bsm_pkg::ST_ADD;
            end
         end
         bsm_pkg::ST_WAIT:
         begin
            // Scan is faster than the documented time, so pad it out
            next_cyc_cnt = 7'(cyc_cnt + 7'h01);
            if (cyc_cnt == limit)
            begin
               next_state = bsm_pkg::ST_IDLE;
            end
         end
         default:
         begin
            next_state = bsm_pkg::ST_IDLE;
         end
      endcase
   end

   // Result group: the product only moves when the padded wait reaches the limit
   always_comb
   begin
      next_result = result;
      next_result.done = 1'b0;
      case (state)
         bsm_pkg::ST_IDLE:
         begin
            next_result.busy = start;
         end
         bsm_pkg::ST_ADD, bsm_pkg::ST_SHIFT:
         begin
            next_result.busy = 1'b1;
         end
         bsm_pkg::ST_WAIT:
         begin
            if (cyc_cnt == limit)
            begin
               // result kept as computed, defect included
               next_result.product = partial;
               next_result.done = 1'b1;
               next_result.busy = 1'b0;
            end
         end
         // Unknown state: drop busy so a caller is not stuck
         default:
         begin
            next_result.busy = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         result <= '0;
      end
      else
      begin
         result <= next_result;
      end
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         state <= bsm_pkg::ST_IDLE;
         mcand <= bsm_pkg::ZERO_WORD;
         mplier <= bsm_pkg::ZERO_WORD;
         prev_bit <= 1'b0;
         partial <= bsm_pkg::ZERO_PROD;
         bit_cnt <= 5'h00;
         cyc_cnt <= 7'h00;
         limit <= 7'h00;
      end
      else
      begin
         state <= next_state;
         mcand <= next_mcand;
         mplier <= next_mplier;
         prev_bit <= next_prev_bit;
         partial <= next_partial;
         bit_cnt <= next_bit_cnt;
         cyc_cnt <= next_cyc_cnt;
         limit <= next_limit;
      end
   end
endmodule

// ==== hdl/bsm_pkg.sv ====
// Constants and types for the signed Booth multiplier
package bsm_pkg;
   localparam int WORD_W = 16;
   localparam int PROD_W = 32;
   localparam int CNT_W = 7;
   localparam int BIT_CNT_W = 5;
   // Per-operation overhead and cost of each bit transition, clock periods
   localparam logic [6:0] OVERHEAD_CYC = 7'h3b;
   localparam logic [6:0] TRANS_CYC = 7'h02;
   localparam logic [4:0] LAST_BIT = 5'h0f;
   localparam logic [15:0] ONE_WORD = 16'h0001;
   localparam logic [15:0] ZERO_WORD = 16'h0000;
   localparam logic [31:0] ZERO_PROD = 32'h0000_0000;

   typedef struct packed
   {
      logic [15:0] a_reg;
      logic [15:0] b_reg;
   } bsm_operand_type;

   typedef struct packed
   {
      logic [31:0] product;
      logic done;
      logic busy;
   } bsm_result_type;

   typedef enum logic [3:0]
   {
      ST_IDLE = 4'h1,
      ST_ADD = 4'h2,
      ST_SHIFT = 4'h4,
      ST_WAIT = 4'h8
   } bsm_state_type;

   typedef enum logic [2:0]
   {
      OP_NONE = 3'h1,
      OP_ADD = 3'h2,
      OP_SUB = 3'h4
   } bsm_op_type;
endpackage

// ==== hdl/bsm_booth_step.sv ====
// Booth recode and add or subtract of the multiplicand
`timescale 1ns/1ps
module bsm_booth_step
(
   // Scan pair and operands
   input wire logic [1:0] pair,
   input wire logic [31:0] partial,
   input wire logic [15:0] mcand,
   // Result of the step
   output logic [31:0] summed,
   output bsm_pkg::bsm_op_type op
);
   logic [15:0] addend;

   always_comb
   begin
      addend = bsm_pkg::ZERO_WORD;
      op = bsm_pkg::OP_NONE;
      case (pair)
         2'b10:
         begin
            op = bsm_pkg::OP_SUB;
            // 16-bit negate, most negative stays negative
            addend = 16'(~mcand + bsm_pkg::ONE_WORD);
         end
         2'b01:
         begin
            op = bsm_pkg::OP_ADD;
            addend = mcand;
         end
         default:
         begin
            op = bsm_pkg::OP_NONE;
            addend = bsm_pkg::ZERO_WORD;
         end
      endcase
      // upper half of 32-bit space, wraps
      summed = 32'(partial + {addend, bsm_pkg::ZERO_WORD});
   end
endmodule

// ==== tb/bsm_multiplier_chk.sv ====
// Checker on the Booth multiplier ports
`timescale 1ns/1ps
module bsm_multiplier_chk
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Command and result
   input wire logic start,
   input wire bsm_pkg::bsm_operand_type operand,
   input wire bsm_pkg::bsm_result_type result
);
   logic [6:0] cnt, next_cnt, lat;
   bsm_pkg::bsm_operand_type cap, next_cap;
   logic [16:0] ext;
   logic signed [31:0] want;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   sequence s_take;
      start && !result.busy;
   endsequence
   // Expected figures from the operands that were taken
   always_comb
   begin
      next_cnt = result.busy ? cnt + 7'h01 : cnt;
      next_cap = cap;
      if (start && !result.busy)
      begin
         // Edges counted from the taking edge, so done sees exactly L
         next_cnt = 7'h00;
         next_cap = operand;
      end
      want = $signed(cap.a_reg) * $signed(cap.b_reg);
      ext = {cap.a_reg, 1'b0};
      lat = 7'h3b;
      for (int i = 0; i < 16; i++)
         lat = lat + {5'h00, ext[i+1] ^ ext[i], 1'b0};
   end
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         cnt <= 7'h00;
         cap <= '0;
      end
      else
      begin
         cnt <= next_cnt;
         cap <= next_cap;
      end
   end
   chk_busy_rise: assert property (s_take |=> result.busy)
      else $error("busy not raised");
   chk_done_window: assert property (s_take |-> ##[60:92] result.done)
      else $error("done missing");
   chk_done_time: assert property (result.done |-> cnt == lat)
      else $error("latency wrong");
   chk_done_pulse: assert property (result.done |=> !result.done)
      else $error("done too long");
   chk_busy_fall: assert property ($fell(result.busy) |-> result.done)
      else $error("busy fell without done");
   chk_prod_hold: assert property
      (!$stable(result.product) |-> result.done) else $error("product moved");
   chk_signed_prod: assert property
      (result.done && cap.b_reg != 16'h8000 |-> result.product == want)
      else $error("product wrong");
   chk_defect_value: assert property
      (result.done && cap == 32'h0001_8000 |-> result.product == 32'h8000)
      else $error("defect value wrong");
endmodule
bind bsm_multiplier bsm_multiplier_chk bsm_multiplier_chk_i (.clk(clk),
   .rst_b(rst_b), .start(start), .operand(operand), .result(result));

// ==== tb/booth_signed_multiplier_bench.sv ====
// Self-checking bench for the Booth multiplier
`timescale 1ns/1ps
module booth_signed_multiplier_bench;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic start = 1'b0;
   bsm_pkg::bsm_operand_type operand = '0;
   bsm_pkg::bsm_result_type result;
   int err_total = 0;
   int n_checks = 0;
   bsm_multiplier bsm_multiplier_i (.clk(clk), .rst_b(rst_b), .start(start),
      .operand(operand), .result(result));
   always #25 clk = ~clk;
   task automatic check(input string what, input logic [31:0] exp, got);
      n_checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic complete_run;
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // One multiply; poke offers a start while busy, which must be ignored
   task automatic mul(input logic [15:0] a, b, input logic [31:0] exp,
      input bit poke);
      logic [16:0] ext;
      int lat;
      int n;
      ext = {a, 1'b0};
      lat = 59;
      n = 0;
      for (int i = 0; i < 16; i++)
         lat += 2 * (ext[i+1] ^ ext[i]);
      @(posedge clk);
      start <= 1'b1;
      operand <= '{a_reg: a, b_reg: b};
      @(posedge clk);
      start <= 1'b0;
      operand <= '0;
      while (result.done !== 1'b1 && n < 200)
      begin
         @(posedge clk);
         start <= poke && n == 9;
         n++;
         #1;
      end
      check("latency", lat, n);
      check("product", exp, result.product);
      check("busy", 32'h0, {31'h0, result.busy});
      if (n >= 200)
         complete_run();
   endtask
   task automatic t_signs;
      mul(16'h0005, 16'h0003, 32'h0000_000f, 0);
      mul(16'h0007, 16'hfffd, 32'hffff_ffeb, 0);
      mul(16'h7fff, 16'h7fff, 32'h3fff_0001, 0);
      mul(16'h0000, 16'h1234, 32'h0000_0000, 0);
      mul(16'hffff, 16'h0009, 32'hffff_fff7, 0);
      mul(16'hfff0, 16'h0007, 32'hffff_ff90, 0);
      mul(16'hffd6, 16'hfffb, 32'h0000_00d2, 0);
      mul(16'h5555, 16'h0003, 32'h0000_ffff, 0);
      $display("test signs done");
   endtask
   task automatic t_defect;
      mul(16'h0001, 16'h8000, 32'h0000_8000, 0);
      mul(16'h8000, 16'h0001, 32'hffff_8000, 0);
      mul(16'h0123, 16'h0011, 32'h0000_1353, 1);
      $display("test defect done");
   endtask
   initial
   begin
      repeat (5) @(posedge clk);
      rst_b <= 1'b1;
      t_signs();
      t_defect();
      complete_run();
   end
endmodule
